// >>> logic/rsd_pkg.sv
/*
  Package for the dual-channel synthesiser divider and lock block.
  Holds register offsets, field positions, reset values and shared types.
  Assumes a host-side serial bus bridge presents parallel 16-bit writes and 8-bit reads.
*/
package rsd_pkg;
  localparam int          N_W            = 20;
  localparam int          R_W            = 13;
  localparam logic [7:0]  ADDR_DATA      = 8'hB2;
  localparam logic [7:0]  ADDR_CTRL      = 8'hB3;
  localparam logic [7:0]  ADDR_STATUS    = 8'hB4;
  // Control fields, channel 1 in the low byte, channel 2 in the high byte; the reference select in bit 5 is shared by both
  localparam int          CTL_EN_POS     = 0;
  localparam int          CTL_PS_POS     = 1;
  localparam int          CTL_SET_POS    = 2;
  localparam int          CTL_GAIN1_POS  = 3;
  localparam int          CTL_GAIN2_POS  = 11;
  localparam int          CTL_TOL_POS    = 4;
  localparam int          CTL_REFSEL_POS = 5;
  localparam int          CTL_CH_STRIDE  = 8;
  localparam logic [15:0] CTL_RESET      = 16'h0000;
  // Data word: bits 15:14 pick channel/set, 13:12 the slice
  localparam int          DAT_CH_POS     = 15;
  localparam int          DAT_SET_POS    = 14;
  localparam int          DAT_SLICE_POS  = 12;
  localparam logic [3:0]  TOL_ONE        = 4'h1;
  localparam logic [3:0]  TOL_FOUR       = 4'h4;
  localparam logic [N_W-1:0] N_RESET     = 20'h00001;
  localparam logic [R_W-1:0] R_RESET     = 13'h0001;

  typedef struct packed {
    logic [N_W-1:0] n;
    logic [R_W-1:0] r;
  } rsd_div_set_t;

  typedef struct packed {
    logic up;
    logic down;
    logic high_gain;
  } rsd_pump_t;
endpackage

// >>> logic/rsd_top.sv
/*
  Two-channel integer-N divider, phase-frequency comparator and lock detector.
  Assumes registered 16-bit writes and 8-bit reads arrive from a bus bridge on clk_i,
  and that the reference and feedback pins come from outside and need synchronising.
*/
`timescale 1ns/10ps
module rsd_top
  import rsd_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        wr_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  output logic      [7:0]  rdata_o,
  input  wire logic        xtal_ref_i,
  input  wire logic        external_synth_ref_clock_i,
  input  wire logic [1:0]  vco_i,
  input  wire logic [7:0]  irq_mask_i,
  output logic             irq_o,
  output rsd_pkg::rsd_pump_t [1:0] pump_o
);
  import rsd_pkg::*;

  logic [15:0]        ctrl_q, ctrl_d;
  rsd_div_set_t [3:0] set_q, set_d;
  logic [1:0]         ref_s1_q, ref_s2_q, ref_s3_q;
  logic [1:0]         vco_s1_q, vco_s2_q, vco_s3_q;
  logic [1:0]         oo_lock_q, oo_lock_d;
  logic [1:0]         lock;

  function automatic logic ch_on(input logic [15:0] c, input int ch);
    ch_on = c[CTL_EN_POS + ch*CTL_CH_STRIDE] && !c[CTL_PS_POS + ch*CTL_CH_STRIDE];
  endfunction

  // Control and divider set registers
  always_comb
  begin
    ctrl_d = ctrl_q;
    set_d  = set_q;
    if (wr_i && addr_i == ADDR_CTRL)
      ctrl_d = wdata_i;
    if (wr_i && addr_i == ADDR_DATA)
    begin
      unique case (wdata_i[DAT_SLICE_POS +: 2])
        2'd0: set_d[wdata_i[DAT_SET_POS +: 2]].n[11:0]  = wdata_i[11:0];
        2'd1: set_d[wdata_i[DAT_SET_POS +: 2]].n[19:12] = wdata_i[7:0];
        2'd2: set_d[wdata_i[DAT_SET_POS +: 2]].r[11:0]  = wdata_i[11:0];
        2'd3: set_d[wdata_i[DAT_SET_POS +: 2]].r[12]    = wdata_i[0];
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      ctrl_q <= CTL_RESET;
      for (int i = 0; i < 4; i++)
        set_q[i] <= '{n: N_RESET, r: R_RESET};
    end
    else
    begin
      ctrl_q <= ctrl_d;
      set_q  <= set_d;
    end
  end

  // Pin synchronisers; stage 3 only feeds edge detection
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      ref_s1_q <= 2'h0;
      ref_s2_q <= 2'h0;
      ref_s3_q <= 2'h0;
      vco_s1_q <= 2'h0;
      vco_s2_q <= 2'h0;
      vco_s3_q <= 2'h0;
    end
    else
    begin
      ref_s1_q <= {external_synth_ref_clock_i, xtal_ref_i};
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
      vco_s1_q <= vco_i;
      vco_s2_q <= vco_s1_q;
      vco_s3_q <= vco_s2_q;
    end
  end

  logic ref_edge;
  assign ref_edge = ctrl_q[CTL_REFSEL_POS] ? (ref_s2_q[1] & ~ref_s3_q[1])
                                           : (ref_s2_q[0] & ~ref_s3_q[0]);

  for (genvar c = 0; c < 2; c++)
  begin : g_ch
    logic [R_W-1:0] rcnt_q, rcnt_d;
    logic [N_W-1:0] ncnt_q, ncnt_d;
    logic           up_q, up_d, dn_q, dn_d;
    logic [3:0]     err_q, err_d;
    logic [2:0]     hist_q, hist_d;
    rsd_div_set_t   act;
    logic           on, vedge, rpulse, npulse;

    assign act    = set_q[{c == 1, ctrl_q[CTL_SET_POS + c*CTL_CH_STRIDE]}];
    assign on     = ch_on(ctrl_q, c);
    assign vedge  = vco_s2_q[c] & ~vco_s3_q[c];
    assign rpulse = ref_edge && rcnt_q == R_W'(1);
    assign npulse = vedge && ncnt_q == N_W'(1);

    always_comb
    begin
      rcnt_d = rcnt_q;
      ncnt_d = ncnt_q;
      up_d   = up_q;
      dn_d   = dn_q;
      err_d  = err_q;
      hist_d = hist_q;
      if (ref_edge)
        rcnt_d = rpulse ? act.r : rcnt_q - R_W'(1);
      if (vedge)
        ncnt_d = npulse ? act.n : ncnt_q - N_W'(1);
      // Phase-frequency comparator arms on each divided edge
      if (rpulse)
        up_d = 1'b1;
      if (npulse)
        dn_d = 1'b1;
      // error width in undivided reference cycles
      if ((up_q ^ dn_q) && ref_edge && err_q != 4'hF)
        err_d = err_q + 4'h1;
      // Both sides fired: reset and measure; aligned edges count as zero error
      if (up_d && dn_d)
      begin
        up_d   = 1'b0;
        dn_d   = 1'b0;
        hist_d = {hist_q[1:0], err_d <=
                  (ctrl_q[CTL_TOL_POS + c*CTL_CH_STRIDE] ? TOL_FOUR : TOL_ONE)};
        err_d  = 4'h0;
      end
      if (!on)
      begin
        rcnt_d = act.r;
        ncnt_d = act.n;
        up_d   = 1'b0;
        dn_d   = 1'b0;
        err_d  = 4'h0;
        hist_d = 3'h0;
      end
    end

    always_ff @(posedge clk_i)
    begin
      if (sys_rst_i)
      begin
        rcnt_q <= R_RESET;
        ncnt_q <= N_RESET;
        up_q   <= 1'b0;
        dn_q   <= 1'b0;
        err_q  <= 4'h0;
        hist_q <= 3'h0;
      end
      else
      begin
        rcnt_q <= rcnt_d;
        ncnt_q <= ncnt_d;
        up_q   <= up_d;
        dn_q   <= dn_d;
        err_q  <= err_d;
        hist_q <= hist_d;
      end
    end

    assign lock[c] = (hist_q[0] & hist_q[1]) | (hist_q[1] & hist_q[2]) | (hist_q[0] & hist_q[2]);
    assign pump_o[c] = '{up: up_q, down: dn_q,
                         high_gain: ctrl_q[c ? CTL_GAIN2_POS : CTL_GAIN1_POS]};
  end

  logic [1:0] lock_q;
  logic [7:0] rdata_d;
  logic       irq_d;

  // sticky loss-of-lock, set wins over clear on status read
  always_comb
  begin
    oo_lock_d = oo_lock_q;
    if (!wr_i && addr_i == ADDR_STATUS)
      oo_lock_d = 2'b00;
    oo_lock_d = oo_lock_d | (lock_q & ~lock);
    rdata_d   = {4'h0, oo_lock_q, lock};
    irq_d     = |(rdata_d & irq_mask_i);
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      oo_lock_q <= 2'b00;
      lock_q    <= 2'b00;
      rdata_o   <= 8'h00;
      irq_o     <= 1'b0;
    end
    else
    begin
      oo_lock_q <= oo_lock_d;
      lock_q    <= lock;
      rdata_o   <= rdata_d;
      irq_o     <= irq_d;
    end
  end
endmodule // rsd_top

// >>> test/rsd_props.sv
/* Port checker for rsd_top.
   Assumes single-cycle write pulses and one clock domain. */
`timescale 1ns/10ps
module rsd_props
  import rsd_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic        wr_i,
  input wire logic [7:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [7:0]  rdata_o,
  input wire logic [7:0]  irq_mask_i,
  input wire logic        irq_o,
  input wire rsd_pump_t [1:0] pump_o
);
  logic [15:0] ctl_q, ctl_d;
  logic [3:0]  age_q, age_d;
  // Control shadow; age saturates so settled checks wait out latency
  always_comb
  begin
    ctl_d = (wr_i && addr_i == ADDR_CTRL) ? wdata_i : ctl_q;
    age_d = (wr_i && addr_i == ADDR_CTRL) ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
  end
  always_ff @(posedge clk_i)
  begin
    ctl_q <= sys_rst_i ? CTL_RESET : ctl_d;
    age_q <= sys_rst_i ? 4'h0 : age_d;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_upper_zero: assert property (rdata_o[7:4] == 4'h0)
    else $error("status high nibble set");
  a_off1_unlocked: assert property (age_q > 4'h3 && (!ctl_q[0] || ctl_q[1]) |-> !rdata_o[0])
    else $error("idle channel 1 reads locked");
  a_off2_unlocked: assert property (age_q > 4'h3 && (!ctl_q[8] || ctl_q[9]) |-> !rdata_o[1])
    else $error("idle channel 2 reads locked");
  a_off1_quiet: assert property (age_q > 4'h3 && !ctl_q[0] |-> !pump_o[0].up && !pump_o[0].down)
    else $error("disabled pump drives");
  a_off2_quiet: assert property (age_q > 4'h3 && !ctl_q[8] |-> !pump_o[1].up && !pump_o[1].down)
    else $error("disabled pump 2 drives");
  a_gain1_follows: assert property (age_q > 4'h3 |-> pump_o[0].high_gain == ctl_q[3])
    else $error("pump 1 gain wrong");
  a_gain2_follows: assert property (age_q > 4'h3 |-> pump_o[1].high_gain == ctl_q[11])
    else $error("pump 2 gain wrong");
  a_mask_blocks: assert property (irq_mask_i == 8'h00 && $past(irq_mask_i) == 8'h00 |-> !irq_o)
    else $error("masked interrupt raised");
  a_loss_flagged: assert property ($fell(rdata_o[0]) && ctl_q[0] && !ctl_q[1] && age_q > 4'h3 |->
    ##[0:3] rdata_o[2])
    else $error("lost lock not flagged");
  c_lock: cover property (rdata_o[0]);
  c_loss: cover property (rdata_o[2]);
  c_irq: cover property (irq_o);
endmodule // rsd_props
bind rsd_top rsd_props u_props (.clk_i, .sys_rst_i, .wr_i, .addr_i, .wdata_i, .rdata_o,
  .irq_mask_i, .irq_o, .pump_o);

// >>> test/rsd_far_model.sv
/* Far side: reference oscillator and two VCOs.
   Assumes rising edges are compared; a good VCO runs at twice the reference. */
`timescale 1ns/10ps
module rsd_far_model
(
  input  wire logic       clk_i,
  input  wire logic       use_ext_i,
  output logic            xtal_o,
  output logic            ext_o,
  output logic [1:0]      vco_o
);
  logic [3:0] t_q = 4'h0;
  // Free-running phase count, reference period 16 cycles
  always @(posedge clk_i)
    t_q <= t_q + 4'h1;
  assign xtal_o = use_ext_i ? 1'b0 : t_q[3];
  assign ext_o  = use_ext_i ? t_q[3] : 1'b0;
  assign vco_o  = {2{~t_q[2]}};
endmodule // rsd_far_model

// >>> test/test_rsd_top.sv
/* Self-checking bench for rsd_top with the far-side model.
   Assumes 20 MHz clock; inputs change 5 ns after a rising edge. */
`timescale 1ns/10ps
module test_rsd_top;
  import rsd_pkg::*;
  logic            clk_i = 1'b0, sys_rst_i = 1'b1, wr_i = 1'b0, use_ext = 1'b0;
  logic [7:0]      addr_i = 8'h00, irq_mask_i = 8'h00, rdata_o;
  logic [15:0]     wdata_i = 16'h0000;
  logic            xtal, ext, irq_o;
  logic [1:0]      vco;
  rsd_pump_t [1:0] pump_o;
  int              n_errors = 0, n_tests = 0, cyc = 0;
  rsd_top DUT (.clk_i, .sys_rst_i, .wr_i, .addr_i, .wdata_i, .rdata_o, .xtal_ref_i(xtal),
    .external_synth_ref_clock_i(ext), .vco_i(vco), .irq_mask_i, .irq_o, .pump_o);
  rsd_far_model u_far (.clk_i, .use_ext_i(use_ext), .xtal_o(xtal), .ext_o(ext), .vco_o(vco));
  initial forever #25 clk_i = !clk_i;
  // Hang guard, well above the sum of all lock waits
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_errors++;
      final_report;
    end
  end
  task automatic final_report;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic step(int n);
    repeat (n) @(posedge clk_i);
    #5;
  endtask
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Strobe stays up so back-to-back writes never toggle it in one step
  task automatic wr(logic [7:0] a, logic [15:0] d);
    wr_i = 1'b1;
    addr_i = a;
    wdata_i = d;
    step(1);
  endtask
  task automatic idle;
    wr_i = 1'b0;
    addr_i = 8'h00;
    step(1);
  endtask
  task automatic load(logic c, logic s, logic [19:0] n, logic [12:0] r);
    wr(ADDR_DATA, {c, s, 2'h0, n[11:0]});
    wr(ADDR_DATA, {c, s, 2'h1, 4'h0, n[19:12]});
    wr(ADDR_DATA, {c, s, 2'h2, r[11:0]});
    wr(ADDR_DATA, {c, s, 2'h3, 11'h000, r[12]});
    idle;
  endtask
  task automatic ctl(logic [15:0] d);
    wr(ADDR_CTRL, d);
    idle;
  endtask
  // Bounded wait for a status bit
  task automatic wait_bit(int b, logic v);
    for (int i = 0; i < 3000 && rdata_o[b] !== v; i++)
      step(1);
  endtask
  task automatic t_lock;
    chk({pump_o, irq_o, rdata_o[0]}, 8'h00);
    load(1'b0, 1'b0, 20'h00002, 13'h0001);
    ctl(16'h0001);
    chk(rdata_o, 8'h00);
    wait_bit(0, 1'b1);
    chk(rdata_o, 8'h01);
    irq_mask_i = 8'h01;
    step(2);
    chk({7'h0, irq_o}, 8'h01);
    irq_mask_i = 8'h00;
    $display("t_lock done");
  endtask
  task automatic t_swap;
    load(1'b0, 1'b1, 20'h00008, 13'h0001);
    chk(rdata_o, 8'h01);
    ctl(16'h0005);
    wait_bit(0, 1'b0);
    step(4);
    chk(rdata_o, 8'h04);
    irq_mask_i = 8'h04;
    step(2);
    chk({7'h0, irq_o}, 8'h01);
    addr_i = ADDR_STATUS;
    step(1);
    addr_i = 8'h00;
    irq_mask_i = 8'h00;
    step(3);
    chk(rdata_o, 8'h00);
    ctl(16'h0015);
    wait_bit(0, 1'b1);
    chk(rdata_o, 8'h01);
    ctl(16'h0019);
    wait_bit(0, 1'b1);
    chk(rdata_o, 8'h01);
    $display("t_swap done");
  endtask
  task automatic t_ch2;
    load(1'b1, 1'b0, 20'h00002, 13'h0001);
    ctl(16'h0903);
    wait_bit(1, 1'b1);
    chk(rdata_o & 8'h03, 8'h02);
    use_ext = 1'b1;
    ctl(16'h0921);
    step(200);
    wait_bit(0, 1'b1);
    chk(rdata_o & 8'h03, 8'h03);
    $display("t_ch2 done");
  endtask
  initial
  begin
    step(10);
    sys_rst_i = 1'b0;
    step(1);
    t_lock;
    t_swap;
    t_ch2;
    final_report;
  end
endmodule // test_rsd_top
